// ==== common/asrc_consts.svh ====
// timing constants and widths for the async sram port controller
`ifndef ASRC_CONSTS_SVH
`define ASRC_CONSTS_SVH
`define ASRC_CLK_NS 40
`define ASRC_ADDR_W 15
`define ASRC_DATA_W 8
// slow grade figures, ns
`define ASRC_T_RC_NS 70
`define ASRC_T_AA_NS 70
`define ASRC_T_OE_NS 50
`define ASRC_T_CW_NS 70
`define ASRC_T_AW_NS 70
`define ASRC_T_WP_NS 50
`define ASRC_T_DW_NS 30
`define ASRC_T_CHZ_NS 35
`define ASRC_T_OHZ_NS 30
`define ASRC_T_RCV_NS 70
// least times round up to whole cycles
`define ASRC_CYC(ns) (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS)
`define ASRC_RD_CYC `ASRC_CYC(`ASRC_T_RC_NS)
`define ASRC_WR_CYC `ASRC_CYC(`ASRC_T_CW_NS)
`define ASRC_HZ_CYC `ASRC_CYC(`ASRC_T_CHZ_NS)
`define ASRC_RCV_CYC `ASRC_CYC(`ASRC_T_RCV_NS)
`define ASRC_CNT_W 3
`endif

// ==== common/asrc_pkg.sv ====
// types for the async sram port controller
`include "asrc_consts.svh"
package asrc_pkg;
  typedef enum logic [2:0] {
    ASRC_IDLE, ASRC_RD, ASRC_WR, ASRC_WREND, ASRC_TURN, ASRC_RETAIN, ASRC_RECOVER
  } asrc_state_e;
  typedef struct packed {
    logic selN;
    logic strobeN;
    logic driveN;
  } asrc_ctl_s;
endpackage

// ==== src/asrc_host.sv ====
// host controller driving an async 32k x 8 sram port
// Rules the memory and this block keep
// RL1 - chip select high keeps memory deselected
// RL2 - select without strobes leaves lines floating
// RL3 - select plus drive enable returns read byte
// RL4 - select plus write strobe stores the byte
// RL5 - fifteen address bits pick one byte
// RL6 - wait full read cycle before sampling data
// RL7 - drive enable access time bounds data valid
// RL8 - memory drives no earlier than after select
// RL9 - memory drives no earlier than after enable
// RL10 - release after deselect within 35 ns
// RL11 - release after drive enable within 30 ns
// RL12 - old data held briefly after address change
// RL13 - write strobe high while address changes
// RL14 - write ends at first rising strobe
// RL15 - select after strobe keeps memory floating
// RL16 - select low long enough for write
// RL17 - address stable long before write ends
// RL18 - data set up before and held after end
// RL19 - memory releases lines after strobe falls
// RL20 - memory drives late after write end
// RL21 - never fight memory output on the lines
// RL22 - deselect before retention, wait after recovery
// RL23 - minimums counted in whole clocks rounded up
`timescale 1ns/10ps
module asrc_host
  import asrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [`ASRC_ADDR_W-1:0] reqAddr,
  input wire logic [`ASRC_DATA_W-1:0] reqData,
  input wire logic retainReq,
  output logic reqReady,
  output logic rdValid,
  output logic [`ASRC_DATA_W-1:0] rdData,
  output logic retainAck,
  output asrc_ctl_s memCtl,
  output logic [`ASRC_ADDR_W-1:0] wordAddress,
  output logic [`ASRC_DATA_W-1:0] dataLinesOut,
  output logic dataLinesOe,
  input wire logic [`ASRC_DATA_W-1:0] dataLinesIn
);
  asrc_state_e state_ff, nxt_state;
  logic [`ASRC_CNT_W-1:0] cnt_ff, nxt_cnt;
  asrc_ctl_s ctl_ff, nxt_ctl;
  logic [`ASRC_ADDR_W-1:0] addr_ff, nxt_addr;
  logic [`ASRC_DATA_W-1:0] wdat_ff, nxt_wdat, rdat_ff, nxt_rdat;
  logic oe_ff, nxt_oe, rdv_ff, nxt_rdv, rdy_ff, nxt_rdy, rack_ff, nxt_rack;
  logic [`ASRC_DATA_W-1:0] dqSync1_ff, dqSync2_ff;
  logic [1:0] rdPipe_ff, nxt_rdPipe;

  function automatic logic [`ASRC_CNT_W-1:0] cyc(input int n);
    cyc = `ASRC_CNT_W'(n);
  endfunction

  // all strobes high: memory deselected and floating
  function automatic asrc_ctl_s ctlOff();
    ctlOff = '{selN: 1'b1, strobeN: 1'b1, driveN: 1'b1};
  endfunction

  // selected with output drive on, write strobe high
  function automatic asrc_ctl_s ctlRead();
    ctlRead = '{selN: 1'b0, strobeN: 1'b1, driveN: 1'b0};
  endfunction

  // select and strobe low together, output drive off
  function automatic asrc_ctl_s ctlWrite();
    ctlWrite = '{selN: 1'b0, strobeN: 1'b0, driveN: 1'b1};
  endfunction

  // request and phase decode
  wire logic cntDone = (cnt_ff == '0);
  wire logic takeReq = rdy_ff && reqValid && !retainReq;
  wire logic takeRead = takeReq && !reqWrite;
  wire logic takeWrite = takeReq && reqWrite;
  // first write cycle: address and data settle before the strobe falls
  wire logic wrSetup = ctl_ff.selN;
  wire logic capture = rdPipe_ff[1];

  // next state and next pin values
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cntDone ? cnt_ff : cnt_ff - cyc(1);
    nxt_ctl = ctl_ff;
    nxt_addr = addr_ff;
    nxt_wdat = wdat_ff;
    nxt_rdat = rdat_ff;
    nxt_oe = oe_ff;
    nxt_rdv = 1'b0;
    nxt_rdy = 1'b0;
    nxt_rack = rack_ff;
    nxt_rdPipe = {rdPipe_ff[0], 1'b0};
    case (state_ff)
      ASRC_IDLE: begin
        // ready drops the cycle after a take
        nxt_rdy = ~retainReq && ~takeReq;
        nxt_ctl = ctlOff(); // [RL1] [RL2]
        if (retainReq) begin
          nxt_state = ASRC_RETAIN; // [RL22]
        end else if (takeWrite) begin
          // address and data settle one cycle with strobe high
          nxt_addr = reqAddr; // [RL5] [RL13]
          nxt_wdat = reqData;
          nxt_oe = 1'b1; // memory deselected here, nothing to fight [RL21]
          nxt_cnt = cyc(`ASRC_WR_CYC); // [RL16] [RL17] [RL18] [RL23]
          nxt_state = ASRC_WR;
        end else if (takeRead) begin
          nxt_addr = reqAddr; // [RL5]
          nxt_oe = 1'b0;
          nxt_ctl = ctlRead(); // [RL3]
          nxt_cnt = cyc(`ASRC_RD_CYC - 1); // [RL6] [RL7] [RL23]
          nxt_state = ASRC_RD;
        end
      end
      ASRC_RD: begin
        if (cntDone) begin
          // two sync stages lie between pin and capture
          nxt_rdPipe = {rdPipe_ff[0], 1'b1}; // [RL6]
          nxt_state = ASRC_TURN;
          nxt_cnt = cyc(`ASRC_HZ_CYC + 1);
        end
      end
      ASRC_WR: begin
        if (wrSetup) begin
          // strobe falls with select: memory stays floating [RL15] [RL21]
          nxt_ctl = ctlWrite(); // [RL4] [RL14]
        end else if (cntDone) begin
          nxt_ctl.strobeN = 1'b1; // [RL14]
          nxt_state = ASRC_WREND;
        end
      end
      ASRC_WREND: begin
        // data held one cycle after strobe rises [RL18]
        nxt_ctl.selN = 1'b1;
        nxt_oe = 1'b0; // [RL21]
        nxt_rdy = 1'b1;
        nxt_state = ASRC_IDLE;
      end
      ASRC_TURN: begin
        // release select and enable, wait for memory to float [RL10] [RL11] [RL12]
        nxt_ctl = ctlOff();
        if (cntDone) begin
          nxt_rdy = 1'b1; // [RL21]
          nxt_state = ASRC_IDLE;
        end
      end
      ASRC_RETAIN: begin
        // ack follows the parked pins by one cycle
        nxt_rack = 1'b1;
        if (!retainReq) begin
          nxt_rack = 1'b0;
          nxt_cnt = cyc(`ASRC_RCV_CYC); // [RL22]
          nxt_state = ASRC_RECOVER;
        end
      end
      ASRC_RECOVER: begin
        // one full read cycle before the next access [RL22]
        if (cntDone) begin
          nxt_rdy = 1'b1;
          nxt_state = ASRC_IDLE;
        end
      end
      default: begin
        nxt_state = ASRC_IDLE;
        nxt_ctl = ctlOff();
      end
    endcase
    if (capture) begin
      nxt_rdat = dqSync2_ff;
      nxt_rdv = 1'b1;
    end
  end

  // read bytes pass two flops; capture waits for both
  always_ff @(posedge clk) begin
    dqSync1_ff <= dataLinesIn;
    dqSync2_ff <= dqSync1_ff;
  end

  // state and pin registers, reset synchronously
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ASRC_IDLE;
      cnt_ff <= '0;
      ctl_ff <= '{selN: 1'b1, strobeN: 1'b1, driveN: 1'b1}; // [RL1]
      addr_ff <= '0;
      wdat_ff <= '0;
      rdat_ff <= '0;
      oe_ff <= 1'b0;
      rdv_ff <= 1'b0;
      rdy_ff <= 1'b0;
      rack_ff <= 1'b0;
      rdPipe_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ctl_ff <= nxt_ctl;
      addr_ff <= nxt_addr;
      wdat_ff <= nxt_wdat;
      rdat_ff <= nxt_rdat;
      oe_ff <= nxt_oe;
      rdv_ff <= nxt_rdv;
      rdy_ff <= nxt_rdy;
      rack_ff <= nxt_rack;
      rdPipe_ff <= nxt_rdPipe;
    end
  end

  // every output straight from a register
  assign memCtl = ctl_ff;
  assign wordAddress = addr_ff;
  assign dataLinesOut = wdat_ff;
  assign dataLinesOe = oe_ff;
  assign reqReady = rdy_ff;
  assign rdValid = rdv_ff;
  assign rdData = rdat_ff;
  assign retainAck = rack_ff;
endmodule

// ==== verif/asrc_mem_model.sv ====
// behavioural model of the async 32k x 8 memory
`timescale 1ns/10ps
`include "asrc_consts.svh"
module asrc_mem_model
  import asrc_pkg::*;
(
  input wire asrc_ctl_s memCtl,
  input wire logic [14:0] wordAddress,
  input wire logic [7:0] dataLinesOut,
  output logic [7:0] dataLinesIn
);
  logic [7:0] mem [0:32767];
  logic [7:0] lastQ = 8'h00;
  wire rdOn = !memCtl.selN && memCtl.strobeN && !memCtl.driveN;
  always @(posedge memCtl.strobeN) if (!memCtl.selN) mem[wordAddress] = dataLinesOut;
  always @(posedge rdOn) lastQ = mem[wordAddress];
  // released lines show the inverse
  // read data appears one address access time after the read starts
  assign #(`ASRC_T_AA_NS) dataLinesIn = rdOn ? mem[wordAddress] : ~lastQ;
endmodule

// ==== verif/asrc_host_asserts.sv ====
// port checks for the async sram host controller
`timescale 1ns/10ps
module asrc_host_asserts
  import asrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic retainReq,
  input wire logic reqReady,
  input wire logic rdValid,
  input wire logic retainAck,
  input wire asrc_ctl_s memCtl,
  input wire logic [14:0] wordAddress,
  input wire logic dataLinesOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire stbN = memCtl.strobeN;
  wire selN = memCtl.selN;
  wire drvN = memCtl.driveN;
  wire takeRd = reqReady && reqValid && !reqWrite && !retainReq;
  a_read_answer: assert property (takeRd |-> ##5 rdValid)
    else $error("read late");
  a_write_nodrive: assert property (!stbN |-> drvN && dataLinesOe)
    else $error("write drive");
  a_oe_nofight: assert property (dataLinesOe |-> drvN)
    else $error("fight");
  a_addr_steady: assert property ($changed(wordAddress) |-> stbN && $past(stbN))
    else $error("addr moved");
  a_strobe_width: assert property ($fell(stbN) |-> ##1 !stbN ##1 stbN)
    else $error("strobe width");
  a_sel_with_stb: assert property ($fell(stbN) |-> $fell(selN))
    else $error("select order");
  a_retain_desel: assert property (retainAck |-> selN)
    else $error("retain select");
  a_idle_quiet: assert property (reqReady |-> &memCtl && !dataLinesOe)
    else $error("idle busy");
  cover property (takeRd);
  cover property ($fell(stbN));
  cover property ($rose(retainAck));
endmodule
bind asrc_host asrc_host_asserts chk (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
  .reqWrite(reqWrite), .retainReq(retainReq), .reqReady(reqReady), .rdValid(rdValid),
  .retainAck(retainAck), .memCtl(memCtl), .wordAddress(wordAddress),
  .dataLinesOe(dataLinesOe));

// ==== verif/tb_top.sv ====
// self-checking bench for the async sram host controller
`timescale 1ns/10ps
module tb_top
  import asrc_pkg::*;
;
  logic clk = 0, rst_n = 0, reqValid = 0, reqWrite = 0, retainReq = 0;
  logic [14:0] reqAddr = 15'h0000;
  logic [7:0] reqData = 8'h00;
  logic reqReady, rdValid, retainAck, dataLinesOe;
  logic [7:0] rdData, dataLinesOut, dataLinesIn;
  logic [14:0] wordAddress;
  asrc_ctl_s memCtl;
  logic [7:0] shadow [logic [14:0]];
  logic [14:0] used [$];
  int fail_count = 0, tests_run = 0;
  always #20 clk = ~clk;
  asrc_host uut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddr(reqAddr), .reqData(reqData), .retainReq(retainReq), .reqReady(reqReady),
    .rdValid(rdValid), .rdData(rdData), .retainAck(retainAck), .memCtl(memCtl),
    .wordAddress(wordAddress), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
    .dataLinesIn(dataLinesIn));
  asrc_mem_model mem (.memCtl(memCtl), .wordAddress(wordAddress),
    .dataLinesOut(dataLinesOut), .dataLinesIn(dataLinesIn));
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic flag(int which);
    return which == 0 ? reqReady : which == 1 ? rdValid : retainAck;
  endfunction
  task automatic waitFor(int which);
    int n;
    n = 0;
    while (flag(which) !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (flag(which) !== 1'b1) begin
      fail_count++;
      $display("[ERR] handshake %0d expected 1 seen %b", which, flag(which));
    end
  endtask
  task automatic access(logic wr, logic [14:0] a, logic [7:0] d);
    waitFor(0);
    reqValid = 1;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    @(posedge clk);
    #1;
    reqValid = 0;
    if (wr) begin
      shadow[a] = d;
      used.push_back(a);
    end else begin
      waitFor(1);
      check("rdData", shadow[a], rdData);
    end
  endtask
  task automatic finish_test();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    logic [14:0] a;
    void'($urandom(32'h7a30));
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1;
    check("memCtl", 8'h07, {5'h00, memCtl});
    access(1, 15'h0000, 8'h5a);
    access(1, 15'h7fff, 8'ha5);
    access(0, 15'h0000, 8'h00);
    access(0, 15'h7fff, 8'h00);
    repeat (24) begin
      a = 15'($urandom);
      access(1, a, 8'($urandom));
      access(0, a, 8'h00);
    end
    retainReq = 1;
    waitFor(2);
    check("selN", 8'h01, {7'h00, memCtl.selN});
    retainReq = 0;
    foreach (used[i]) access(0, used[i], 8'h00);
    finish_test();
  end
endmodule
